// >>> audio_clock_afs_config.sv
`timescale 1ns/1ps
module audio_clock_afs_config #(
	parameter int FIELDS_PER_SYNC = 5,
	parameter int FIELD_CNT_W = 4
) (
	// clock and reset
	input logic core_clk,
	input logic rst_n,
	// register port
	input audio_clock_afs_pkg::reg_req_t reg_req,
	output logic [15:0] reg_rdata,
	// timing core strobes
	input logic line_pulse,
	input logic field_pulse,
	// pins
	input logic field_ident_ref_in,
	input logic [2:0] sample_rate_select_pins,
	// audio frame sync and rate
	output logic audio_frame_sync,
	output logic [2:0] sample_rate,
	// loop bandwidth
	output logic [5:0] loop_param_a,
	output logic [5:0] loop_param_b,
	output logic [2:0] reset_window,
	// audio clock selections
	output audio_clock_afs_pkg::aclk_cfg_t audio_clock_out_one,
	output audio_clock_afs_pkg::aclk_cfg_t audio_clock_out_two,
	output audio_clock_afs_pkg::aclk_cfg_t audio_clock_out_three
);

	// ==========================================================
	// registers
	logic frame_sync_ref_reset_off;
	logic frame_sync_stretch;
	logic host_rate_override;
	logic mid_multiple_enable;
	logic [2:0] window;
	logic [2:0] host_code;
	logic [5:0] loop_a;
	logic [5:0] loop_b;
	logic loop_a_user;
	logic loop_b_user;
	logic [2:0] mult [3];
	logic ref_s1;
	logic ref_s2;
	logic ref_s3;
	logic [2:0] pins_s1;
	logic [2:0] pins_s2;
	logic [FIELD_CNT_W-1:0] field_cnt;
	logic fs_active;
	logic seen_rate_write;
	logic seen_mult_write;

	// ==========================================================
	// bus decode
	wire wr_ctrl = reg_req.wr && reg_req.addr == audio_clock_afs_pkg::ADDR_AUDIO_CONTROL;
	wire wr_rate = reg_req.wr && reg_req.addr == audio_clock_afs_pkg::ADDR_HOST_RATE;
	wire wr_la = reg_req.wr && reg_req.addr == audio_clock_afs_pkg::ADDR_LOOP_A;
	wire wr_lb = reg_req.wr && reg_req.addr == audio_clock_afs_pkg::ADDR_LOOP_B;
	wire wr_restart = reg_req.wr && reg_req.addr == audio_clock_afs_pkg::ADDR_FS_RESTART;
	wire [2:0] wr_mult;
	assign wr_mult[0] = reg_req.wr && reg_req.addr == audio_clock_afs_pkg::ADDR_OUT1_MULT;
	assign wr_mult[1] = reg_req.wr && reg_req.addr == audio_clock_afs_pkg::ADDR_OUT2_MULT;
	assign wr_mult[2] = reg_req.wr && reg_req.addr == audio_clock_afs_pkg::ADDR_OUT3_MULT;

	// reserved bits are dropped on write and read back as zero
	wire [15:0] ctrl_view = {6'h00, window, 1'b0, mid_multiple_enable, 2'h0,
		host_rate_override, frame_sync_stretch, frame_sync_ref_reset_off};
	logic [15:0] next_rdata;
	always_comb begin
		case (reg_req.addr)
			audio_clock_afs_pkg::ADDR_AUDIO_CONTROL: next_rdata = ctrl_view;
			audio_clock_afs_pkg::ADDR_HOST_RATE: next_rdata = {13'h0000, host_code};
			audio_clock_afs_pkg::ADDR_LOOP_A: next_rdata = {10'h000, loop_a};
			audio_clock_afs_pkg::ADDR_LOOP_B: next_rdata = {10'h000, loop_b};
			audio_clock_afs_pkg::ADDR_OUT1_MULT: next_rdata = {13'h0000, mult[0]};
			audio_clock_afs_pkg::ADDR_OUT2_MULT: next_rdata = {13'h0000, mult[1]};
			audio_clock_afs_pkg::ADDR_OUT3_MULT: next_rdata = {13'h0000, mult[2]};
			default: next_rdata = 16'h0000;
		endcase
	end

	// ==========================================================
	// control registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_sync_ref_reset_off <= 1'b0;
			frame_sync_stretch <= 1'b0;
			host_rate_override <= 1'b0;
			mid_multiple_enable <= 1'b0;
			window <= audio_clock_afs_pkg::RESET_WINDOW_RST;
		end else if (wr_ctrl) begin
			frame_sync_ref_reset_off <= reg_req.wdata[audio_clock_afs_pkg::CTRL_REF_OFF_BIT];
			frame_sync_stretch <= reg_req.wdata[audio_clock_afs_pkg::CTRL_STRETCH_BIT];
			host_rate_override <= reg_req.wdata[audio_clock_afs_pkg::CTRL_OVERRIDE_BIT];
			mid_multiple_enable <= reg_req.wdata[audio_clock_afs_pkg::CTRL_MID_EN_BIT];
			window <= reg_req.wdata[audio_clock_afs_pkg::CTRL_WIN_MSB:audio_clock_afs_pkg::CTRL_WIN_LSB];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_code <= audio_clock_afs_pkg::RATE_48K;
			seen_rate_write <= 1'b0;
		end else if (wr_rate) begin
			host_code <= reg_req.wdata[2:0];
			seen_rate_write <= 1'b1;
		end
	end

	// ==========================================================
	// sample rate selection
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_s1 <= 3'h0;
			pins_s2 <= 3'h0;
		end else begin
			pins_s1 <= sample_rate_select_pins;
			pins_s2 <= pins_s1;
		end
	end
	wire [2:0] next_rate = host_rate_override ? host_code : pins_s2;

	// ==========================================================
	// loop bandwidth: follows the rate until software writes it
	wire [5:0] def_a = audio_clock_afs_pkg::LOOP_A_BASE + {3'h0, next_rate};
	wire [5:0] def_b = audio_clock_afs_pkg::LOOP_B_BASE + {3'h0, next_rate};
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			loop_a <= audio_clock_afs_pkg::LOOP_A_BASE;
			loop_b <= audio_clock_afs_pkg::LOOP_B_BASE;
			loop_a_user <= 1'b0;
			loop_b_user <= 1'b0;
		end else begin
			if (wr_la) begin
				loop_a <= reg_req.wdata[5:0];
				loop_a_user <= 1'b1;
			end else if (!loop_a_user) begin
				loop_a <= def_a;
			end
			if (wr_lb) begin
				loop_b <= reg_req.wdata[5:0];
				loop_b_user <= 1'b1;
			end else if (!loop_b_user) begin
				loop_b <= def_b;
			end
		end
	end

	// ==========================================================
	// audio clock multiple selection
	logic [2:0] next_mult [3];
	logic [2:0] next_drive;
	logic [2:0] next_third;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_out
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					mult[gi] <= audio_clock_afs_pkg::MULT_RST;
				end else if (wr_mult[gi]) begin
					mult[gi] <= reg_req.wdata[2:0];
				end
			end
			wire is_mid = mult[gi] == audio_clock_afs_pkg::MULT_384 ||
				mult[gi] == audio_clock_afs_pkg::MULT_192;
			// mid multiples without the enable fall back to high impedance
			assign next_mult[gi] = (is_mid && !mid_multiple_enable) ?
				audio_clock_afs_pkg::MULT_HIZ : mult[gi];
			assign next_drive[gi] = next_mult[gi] != audio_clock_afs_pkg::MULT_HIZ;
			assign next_third[gi] = mid_multiple_enable &&
				next_rate == audio_clock_afs_pkg::RATE_96K &&
				mult[gi] == audio_clock_afs_pkg::MULT_512;
		end
	endgenerate

	// ==========================================================
	// audio frame sync generator
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_s1 <= 1'b0;
			ref_s2 <= 1'b0;
			ref_s3 <= 1'b0;
		end else begin
			ref_s1 <= field_ident_ref_in;
			ref_s2 <= ref_s1;
			ref_s3 <= ref_s2;
		end
	end
	wire ref_edge = ref_s2 && !ref_s3;
	wire restart = wr_restart || (ref_edge && !frame_sync_ref_reset_off);
	wire wrap = field_pulse && field_cnt == FIELD_CNT_W'(FIELDS_PER_SYNC - 1);
	wire fs_end = frame_sync_stretch ? field_pulse : line_pulse;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			field_cnt <= '0;
			fs_active <= 1'b0;
		end else if (restart) begin
			field_cnt <= '0;
			fs_active <= 1'b1;
		end else if (field_pulse) begin
			field_cnt <= wrap ? '0 : field_cnt + 1'b1;
			fs_active <= wrap || (fs_active && !fs_end);
		end else if (fs_active && fs_end) begin
			fs_active <= 1'b0;
		end
	end

	// ==========================================================
	// output flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
			audio_frame_sync <= 1'b0;
			sample_rate <= audio_clock_afs_pkg::RATE_48K;
			loop_param_a <= audio_clock_afs_pkg::LOOP_A_BASE;
			loop_param_b <= audio_clock_afs_pkg::LOOP_B_BASE;
			reset_window <= audio_clock_afs_pkg::RESET_WINDOW_RST;
			audio_clock_out_one <= '0;
			audio_clock_out_two <= '0;
			audio_clock_out_three <= '0;
		end else begin
			reg_rdata <= reg_req.rd ? next_rdata : 16'h0000;
			audio_frame_sync <= fs_active;
			sample_rate <= next_rate;
			loop_param_a <= loop_a;
			loop_param_b <= loop_b;
			reset_window <= window;
			audio_clock_out_one <= '{next_drive[0], next_mult[0], next_third[0]};
			audio_clock_out_two <= '{next_drive[1], next_mult[1], next_third[1]};
			audio_clock_out_three <= '{next_drive[2], next_mult[2], next_third[2]};
		end
	end

	// ==========================================================
	// checks
	AST_LINE_END: assert property (@(posedge core_clk) disable iff (!rst_n)
		fs_active && !frame_sync_stretch && line_pulse && !field_pulse && !restart
		|=> !fs_active ##1 !audio_frame_sync)
		else $error("frame sync outlived its line");

	AST_FIELD_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		fs_active && frame_sync_stretch && line_pulse && !field_pulse && !restart
		|=> fs_active ##1 audio_frame_sync)
		else $error("stretched frame sync ended on a line");

	AST_REF_IGNORED: assert property (@(posedge core_clk) disable iff (!rst_n)
		frame_sync_ref_reset_off && ref_edge && !wr_restart && !field_pulse
		|=> $stable(field_cnt))
		else $error("reference restarted frame sync while disabled");

	AST_REF_RESTART: assert property (@(posedge core_clk) disable iff (!rst_n)
		!frame_sync_ref_reset_off && ref_edge
		|=> fs_active && field_cnt == '0 ##1 audio_frame_sync)
		else $error("reference edge did not restart frame sync");

	AST_SW_RESTART: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_restart |=> fs_active && field_cnt == '0 ##1 audio_frame_sync)
		else $error("software restart ignored");

	AST_HOST_RATE: assert property (@(posedge core_clk) disable iff (!rst_n)
		host_rate_override && !wr_ctrl && !wr_rate
		|=> sample_rate == $past(host_code))
		else $error("sample rate did not follow host code");

	AST_RATE_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
		!seen_rate_write |-> host_code == audio_clock_afs_pkg::RATE_48K)
		else $error("host rate code lost its reset value");

	AST_LOOP_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_la |=> ##1 loop_param_a == $past(reg_req.wdata[5:0], 2))
		else $error("loop value a not applied");

	AST_LOOP_DEFAULT: assert property (@(posedge core_clk) disable iff (!rst_n)
		!loop_b_user && !wr_lb |=> loop_b == $past(def_b))
		else $error("loop value b did not track rate");

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_mult_write <= 1'b0;
		end else if (wr_mult[0]) begin
			seen_mult_write <= 1'b1;
		end
	end
	AST_MULT_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
		!seen_mult_write |-> mult[0] == audio_clock_afs_pkg::MULT_RST)
		else $error("output one multiple lost its reset value");

	AST_MID_BLOCKED: assert property (@(posedge core_clk) disable iff (!rst_n)
		!mid_multiple_enable && mult[1] == audio_clock_afs_pkg::MULT_192
		|=> !audio_clock_out_two.drive)
		else $error("192fs produced without enable");

	AST_THIRD_DUTY: assert property (@(posedge core_clk) disable iff (!rst_n)
		mid_multiple_enable && next_rate == audio_clock_afs_pkg::RATE_96K &&
		mult[2] == audio_clock_afs_pkg::MULT_512
		|=> audio_clock_out_three.third_duty && audio_clock_out_three.drive)
		else $error("512fs at 96 kHz lacks one-third duty");

endmodule

// >>> audio_clock_afs_pkg.sv
package audio_clock_afs_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] ADDR_FS_RESTART = 8'h1a;
	localparam logic [7:0] ADDR_AUDIO_CONTROL = 8'h31;
	localparam logic [7:0] ADDR_HOST_RATE = 8'h32;
	localparam logic [7:0] ADDR_LOOP_A = 8'h39;
	localparam logic [7:0] ADDR_LOOP_B = 8'h3a;
	localparam logic [7:0] ADDR_OUT1_MULT = 8'h3f;
	localparam logic [7:0] ADDR_OUT2_MULT = 8'h40;
	localparam logic [7:0] ADDR_OUT3_MULT = 8'h41;

	// ==========================================================
	// audio control fields
	localparam int CTRL_REF_OFF_BIT = 0;
	localparam int CTRL_STRETCH_BIT = 1;
	localparam int CTRL_OVERRIDE_BIT = 2;
	localparam int CTRL_MID_EN_BIT = 5;
	localparam int CTRL_WIN_LSB = 7;
	localparam int CTRL_WIN_MSB = 9;
	localparam logic [2:0] RESET_WINDOW_RST = 3'h2;

	// ==========================================================
	// sample rate and loop defaults
	localparam logic [2:0] RATE_48K = 3'h3;
	localparam logic [2:0] RATE_96K = 3'h5;
	localparam logic [5:0] LOOP_A_BASE = 6'h0a;
	localparam logic [5:0] LOOP_B_BASE = 6'h20;

	// ==========================================================
	// fs multiple encoding
	localparam logic [2:0] MULT_512 = 3'h0;
	localparam logic [2:0] MULT_384 = 3'h1;
	localparam logic [2:0] MULT_256 = 3'h2;
	localparam logic [2:0] MULT_192 = 3'h3;
	localparam logic [2:0] MULT_128 = 3'h4;
	localparam logic [2:0] MULT_64 = 3'h5;
	localparam logic [2:0] MULT_FS = 3'h6;
	localparam logic [2:0] MULT_HIZ = 3'h7;
	localparam logic [2:0] MULT_RST = 3'h0;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic drive;
		logic [2:0] multiple;
		logic third_duty;
	} aclk_cfg_t;

endpackage

// >>> audio_sink_model.sv
`timescale 1ns/1ps
module audio_sink_model #(
	parameter int LINE_CYC = 8,
	parameter int LINES = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// timing strobes towards the block
	output logic line_pulse,
	output logic field_pulse,
	// frame sync as seen downstream
	input wire logic audio_frame_sync,
	output int sync_len
);
	// ==========================================================
	// line and field strobes, frame sync length meter
	int cyc;
	int run;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc <= 1;
			run <= 0;
			sync_len <= 0;
			line_pulse <= 1'b0;
			field_pulse <= 1'b0;
		end else begin
			cyc <= cyc + 1;
			line_pulse <= (cyc % LINE_CYC) == 0;
			field_pulse <= (cyc % (LINE_CYC * LINES)) == 0;
			run <= audio_frame_sync ? run + 1 : 0;
			if (!audio_frame_sync && run != 0) begin
				sync_len <= run;
			end
		end
	end
endmodule

// >>> test_audio_clock_afs_config.sv
`timescale 1ns/1ps
module test_audio_clock_afs_config;
	// ==========================================================
	// signals
	logic core_clk;
	logic rst_n;
	audio_clock_afs_pkg::reg_req_t reg_req;
	logic [15:0] reg_rdata;
	logic line_pulse;
	logic field_pulse;
	logic field_ident_ref_in;
	logic [2:0] sample_rate_select_pins;
	logic audio_frame_sync;
	logic [2:0] sample_rate;
	logic [5:0] loop_param_a;
	logic [5:0] loop_param_b;
	logic [2:0] reset_window;
	audio_clock_afs_pkg::aclk_cfg_t outs [3];
	int num_errors = 0;
	int total_checks = 0;
	int sync_len;
	logic [31:0] seed = 32'h0000001c;
	logic [15:0] d;
	logic [5:0] la;
	logic [5:0] lb;
	logic [2:0] pins;

	audio_clock_afs_config #(.FIELDS_PER_SYNC(2), .FIELD_CNT_W(4)) DUT (
		.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.line_pulse(line_pulse), .field_pulse(field_pulse),
		.field_ident_ref_in(field_ident_ref_in),
		.sample_rate_select_pins(sample_rate_select_pins),
		.audio_frame_sync(audio_frame_sync), .sample_rate(sample_rate),
		.loop_param_a(loop_param_a), .loop_param_b(loop_param_b), .reset_window(reset_window),
		.audio_clock_out_one(outs[0]), .audio_clock_out_two(outs[1]),
		.audio_clock_out_three(outs[2]));
	audio_sink_model #(.LINE_CYC(8), .LINES(4)) sink (
		.core_clk(core_clk), .rst_n(rst_n), .line_pulse(line_pulse),
		.field_pulse(field_pulse), .audio_frame_sync(audio_frame_sync), .sync_len(sync_len));

	// ==========================================================
	// helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [4:0] exp_cfg(input logic [2:0] c, input logic mid, input logic r96);
		logic off;
		off = (c == 3'h7) || (!mid && (c == 3'h1 || c == 3'h3));
		return off ? {1'b0, 3'h7, 1'b0} : {1'b1, c, mid && r96 && c == 3'h0};
	endfunction
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		reg_req <= '0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		reg_req <= '0;
		#1 v = reg_rdata;
		@(posedge core_clk);
	endtask
	task automatic settle();
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	task automatic wait_lvl(input logic v);
		for (int i = 0; i < 200 && audio_frame_sync !== v; i++) @(posedge core_clk);
	endtask
	task automatic ref_edge(input logic e, input string n);
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		repeat (2) @(posedge core_clk);
		field_ident_ref_in <= 1'b1;
		repeat (6) @(posedge core_clk);
		#1 chk(n, {15'h0, e}, {15'h0, audio_frame_sync});
		@(posedge core_clk);
		field_ident_ref_in <= 1'b0;
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// clock, watchdog
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		end_sim();
	end

	// ==========================================================
	// tests
	initial begin
		rst_n = 1'b0;
		reg_req = '0;
		field_ident_ref_in = 1'b0;
		pins = 3'(xs());
		sample_rate_select_pins = pins;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd(8'h31, d);
		chk("ctrl_reset", 16'h0100, d);
		rd(8'h32, d);
		chk("host_rate_reset", 16'h0003, d);
		#1 chk("rdata_idle", 16'h0000, reg_rdata);
		for (int k = 0; k < 3; k++) begin
			rd(8'(8'h3f + k), d);
			chk("mult_reset", 16'h0000, d);
		end
		rd(8'h33, d);
		chk("reserved_read", 16'h0000, d);
		settle();
		chk("rate_pins", 16'(pins), 16'(sample_rate));
		chk("loop_a_dflt", 16'(6'h0a + pins), 16'(loop_param_a));
		chk("loop_b_dflt", 16'(6'h20 + pins), 16'(loop_param_b));
		chk("window_rst", 16'h0002, 16'(reset_window));
		$display("test reset done");
		wr(8'h31, 16'h0104);
		settle();
		chk("rate_host", 16'h0003, 16'(sample_rate));
		chk("loop_a_48k", 16'h000d, 16'(loop_param_a));
		wr(8'h32, 16'h0005);
		settle();
		chk("rate_96k", 16'h0005, 16'(sample_rate));
		chk("loop_b_96k", 16'h0025, 16'(loop_param_b));
		lb = 6'd32 + 6'(xs() % 11);
		la = 6'd10 + 6'(xs() % (lb - 30));
		wr(8'h3a, {10'h0, lb});
		wr(8'h39, {10'h0, la});
		wr(8'h33, 16'h0015);
		rd(8'h39, d);
		chk("loop_a_read", {10'h0, la}, d);
		settle();
		chk("loop_a", 16'(la), 16'(loop_param_a));
		chk("loop_b", 16'(lb), 16'(loop_param_b));
		$display("test rate and loop done");
		repeat (150) @(posedge core_clk);
		#1 chk("sync_line", 16'd8, 16'(sync_len));
		wr(8'h31, 16'h0106);
		repeat (150) @(posedge core_clk);
		#1 chk("sync_field", 16'd32, 16'(sync_len));
		ref_edge(1'b1, "ref_restart");
		wr(8'h31, 16'h0107);
		ref_edge(1'b0, "ref_ignored");
		wr(8'h1a, 16'(xs()));
		#1 chk("soft_restart", 16'h0001, {15'h0, audio_frame_sync});
		$display("test frame sync done");
		for (int m = 0; m < 4; m++) begin
			wr(8'h31, 16'h0004 | (16'(m) << 7) | (16'(m[0]) << 5));
			wr(8'h32, m[1] ? 16'h0005 : 16'h0003);
			for (int c = 0; c < 8; c++) begin
				for (int k = 0; k < 3; k++) wr(8'(8'h3f + k), 16'((c + k) % 8));
				settle();
				for (int k = 0; k < 3; k++) begin
					chk("aclk_cfg", 16'(exp_cfg(3'((c + k) % 8), m[0], m[1])), 16'(outs[k]));
				end
			end
			chk("window", 16'(m), 16'(reset_window));
		end
		$display("test fs multiples done");
		end_sim();
	end
endmodule
